// >>> pkg/pap_pkg.sv
// constants for the pager address packet port
// Operation
// [RQ1] sixteen address slots, set by packets 128..143, slot number in byte 3 low nibble
// [RQ2] host clears a slot's enable bit before altering that slot's assignment
// [RQ3] long address: both slots flagged long, first even, second right after
// [RQ4] host places 2-3 and 2-4 long addresses above 1-x long addresses
// [RQ5] tone-only slot match decodes no vector word
// [RQ6] host sets tone-only on both words of a long address
// [RQ7] each slot holds a 21-bit address from bytes 2..0; host loads valid ones
// [RQ8] outgoing packets leave most significant bit first, packet bit 31 first
// [RQ9] while checksum-disabled, the part identity packet goes out every slot
// [RQ10] data packets from received words queue in a 32-packet buffer
// [RQ11] enabled: send oldest buffered packet, else the unbuffered status packet
// [RQ12] buffer overflow stops decoding and discards the whole buffer
// [RQ13] first block information word of each phase is never forwarded
// [RQ14] info words of format 001, 010, 101 forwarded only with send flag set
// [RQ15] with send flag set, errored info words go out with error flag set
// [RQ16] no vector or message decode after a format 101 info word
// [RQ17] info packet: id 0, error bit 7, phase 6..5, format 2..0, 14 info bits
// [RQ18] error flag set for more than 2 bit errors or failed check character
// [RQ19] error flag clear implies format is 001, 010 or 101
// [RQ20] info bits packed per format: date, time, or system message
// [RQ21] address packet only for under three bit errors matching an enabled slot
// [RQ22] address packet: id 1, priority, phase, long flag, index, tone-only, word number
// [RQ23] only slots with the enable bit set take part in matching
// [RQ24] index 0..15 for slots, 128..143 temporary; long reports once, second word
// [RQ25] tone-only address packet is followed by no vector packet
// [RQ26] host packets routed by byte 3 id, slot updated only on complete packet
package pap_pkg;
  localparam int PAP_SLOTS = 16;
  localparam int PAP_DEPTH = 32;
  localparam int PAP_PKT_BITS = 32;
  localparam logic [7:0] PAP_ID_ASSIGN_HI = 8'h80;
  localparam logic [3:0] PAP_ASSIGN_NIBBLE = 4'h8;
  localparam logic [7:0] PAP_ID_INFO = 8'h00;
  localparam logic [7:0] PAP_ID_ADDRESS = 8'h01;
  localparam logic [3:0] PAP_TEMP_NIBBLE = 4'h8;
  localparam int PAP_ASSIGN_LONG_BIT = 22;
  localparam int PAP_ASSIGN_TONE_BIT = 21;
  localparam logic [2:0] PAP_FMT_DATE = 3'h1;
  localparam logic [2:0] PAP_FMT_TIME = 3'h2;
  localparam logic [2:0] PAP_FMT_SYSMSG = 3'h5;
  localparam logic [1:0] PAP_MAX_GOOD_ERRS = 2'h2;
  // register byte addresses
  localparam logic [7:0] PAP_REG_CONTROL = 8'h00;
  localparam logic [7:0] PAP_REG_SLOT_ENABLE = 8'h04;
  localparam logic [7:0] PAP_REG_STATUS = 8'h08;
  localparam logic [7:0] PAP_REG_STATUS_PKT = 8'h0c;
  // control fields
  localparam int PAP_CTL_SEND_INFO = 0;
  localparam int PAP_CTL_DECODE_ON = 1;
  localparam int PAP_CTL_CLR_OVF = 2;
  // status fields
  localparam int PAP_ST_OVF = 8;
  localparam int PAP_ST_CKSUM_OFF = 9;
  localparam logic [31:0] PAP_RESET_STATUS_PKT = 32'h00000000;
  localparam logic [1:0] PAP_HTRANS_NONSEQ = 2'h2;
endpackage

// >>> rtl/pap_port.sv
// packet layer of the decoder's host serial port with AHB-Lite register access
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module pap_port #(
  parameter logic [31:0] PART_ID_WORD = 32'h7e5a0001 // arbitrary identity value
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic spi_sck, // host serial clock, pin
  input wire logic spi_mosi, // host to decoder data, pin
  input wire logic spi_ss_n, // frame select, active low, pin
  output logic spi_miso, // decoder to host data
  output logic spi_miso_oe_n, // miso drive enable, active low
  input wire logic checksum_off, // decoder disabled by checksum
  input wire logic rx_info_valid, // received block information word
  input wire logic rx_info_first, // first info word of its phase
  input wire logic [1:0] rx_phase, // phase of the received word
  input wire logic [1:0] rx_bit_errs, // bit errors, saturating at 3
  input wire logic rx_check_fail, // check character failed
  input wire logic [2:0] rx_info_format, // info word format field
  input wire logic [13:0] rx_info_bits, // info bits, packed per format
  input wire logic rx_addr_valid, // received address word
  input wire logic [20:0] rx_addr_value, // received address value
  input wire logic rx_addr_priority, // received as priority address
  input wire logic [6:0] rx_vector_wn, // vector word number
  input wire logic rx_temp_hit, // temporary address matched upstream
  input wire logic [3:0] rx_temp_index, // which temporary address
  input wire logic rx_pkt_valid, // prebuilt vector or message packet
  input wire logic [31:0] rx_pkt_data, // that packet
  output logic decode_on, // decoding running
  output logic vector_skip // pulse: do not decode the vector or messages
);
  import pap_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // functions
  function automatic logic info_format_ok(input logic [2:0] f);
    info_format_ok = (f == PAP_FMT_DATE) || (f == PAP_FMT_TIME) || (f == PAP_FMT_SYSMSG);
  endfunction

  function automatic logic [4:0] first_set(input logic [PAP_SLOTS-1:0] v);
    first_set = 5'h10;
    for (int i = PAP_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction

  // slot number of an assignment packet, low nibble of its id byte
  function automatic logic [3:0] slot_of(input logic [31:0] w);
    slot_of = w[27:24];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register bus
  logic send_info;
  logic decode_en;
  logic overflow;
  logic [PAP_SLOTS-1:0] slot_enable_bit;
  logic [31:0] status_pkt;
  logic [7:0] wr_addr;
  logic wr_pend;
  logic [5:0] fifo_count;
  logic ovf_event;
  logic bus_take;
  logic [31:0] rd_word;

  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel && hready && (htrans == PAP_HTRANS_NONSEQ);
  // an overflow stops decoding until software clears it
  assign decode_on = decode_en && !overflow;

  always_comb begin
    unique case (haddr[7:0])
      PAP_REG_CONTROL: rd_word = {30'h0, decode_en, send_info};
      PAP_REG_SLOT_ENABLE: rd_word = {16'h0, slot_enable_bit};
      PAP_REG_STATUS: rd_word = {22'h0, checksum_off, overflow, 2'h0, fifo_count};
      PAP_REG_STATUS_PKT: rd_word = status_pkt;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
      hrdata <= 32'h0;
    end else if (clk_en) begin
      // write data only arrives in the data phase, so the target is kept
      wr_pend <= bus_take && hwrite;
      wr_addr <= haddr[7:0];
      if (bus_take && !hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_info <= 1'b0;
      decode_en <= 1'b0;
      slot_enable_bit <= '0;
      status_pkt <= PAP_RESET_STATUS_PKT;
    end else if (clk_en && wr_pend) begin
      unique case (wr_addr)
        PAP_REG_CONTROL: begin
          send_info <= hwdata[PAP_CTL_SEND_INFO];
          decode_en <= hwdata[PAP_CTL_DECODE_ON];
        end
        PAP_REG_SLOT_ENABLE: slot_enable_bit <= hwdata[15:0];
        PAP_REG_STATUS_PKT: status_pkt <= hwdata;
        default: ;
      endcase
    end
  end

  // overflow latch; a new overflow wins over a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow <= 1'b0;
    end else if (clk_en) begin
      if (ovf_event) begin
        overflow <= 1'b1; // RQ12
      end else if (wr_pend && wr_addr == PAP_REG_CONTROL && hwdata[PAP_CTL_CLR_OVF]) begin
        overflow <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial pins: two-flop synchronisers, then edge detection
  logic [1:0] sck_sync;
  logic [1:0] mosi_sync;
  logic [1:0] ss_sync;
  logic sck_last;
  logic ss_last;
  logic sck_rise;
  logic sck_fall;
  logic frame_start;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // idle levels, so release from reset shows no false edge
      sck_sync <= 2'b00;
      mosi_sync <= 2'b00;
      ss_sync <= 2'b11;
      sck_last <= 1'b0;
      ss_last <= 1'b1;
    end else if (clk_en) begin
      sck_sync <= {sck_sync[0], spi_sck};
      mosi_sync <= {mosi_sync[0], spi_mosi};
      ss_sync <= {ss_sync[0], spi_ss_n};
      sck_last <= sck_sync[1];
      ss_last <= ss_sync[1];
    end
  end

  assign sck_rise = sck_sync[1] && !sck_last && !ss_sync[1];
  assign sck_fall = !sck_sync[1] && sck_last && !ss_sync[1];
  assign frame_start = ss_last && !ss_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer
  logic [31:0] fifo_mem [PAP_DEPTH];
  logic [4:0] fifo_wr;
  logic [4:0] fifo_rd;
  logic push;
  logic [31:0] push_data;
  logic pop;

  assign ovf_event = push && (fifo_count == 6'(PAP_DEPTH));

  // storage has no reset; pointers and count say what is valid
  always_ff @(posedge hclk) begin
    if (clk_en && push && !ovf_event) begin
      fifo_mem[fifo_wr] <= push_data; // RQ10
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_wr <= 5'h0;
      fifo_rd <= 5'h0;
      fifo_count <= 6'h0;
    end else if (clk_en) begin
      if (ovf_event) begin
        fifo_wr <= 5'h0; // RQ12
        fifo_rd <= 5'h0;
        fifo_count <= 6'h0;
      end else begin
        if (push) begin
          fifo_wr <= fifo_wr + 5'h1;
        end
        if (pop) begin
          fifo_rd <= fifo_rd + 5'h1;
        end
        fifo_count <= fifo_count + 6'(push) - 6'(pop);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outgoing packet selection and shifter
  logic [31:0] tx_shift;
  logic [31:0] tx_pick;

  // pick at frame start so the first bit is ready before the first rising edge
  assign pop = frame_start && !checksum_off && fifo_count != 6'h0 && !ovf_event; // RQ11

  // a head that an overflow discards in the same cycle is not sent
  always_comb begin
    if (checksum_off) begin
      tx_pick = PART_ID_WORD; // RQ9
    end else if (pop) begin
      tx_pick = fifo_mem[fifo_rd]; // RQ11
    end else begin
      tx_pick = status_pkt; // RQ11
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_shift <= 32'h0;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (clk_en) begin
      spi_miso_oe_n <= ss_sync[1];
      if (frame_start) begin
        tx_shift <= {tx_pick[30:0], 1'b0};
        spi_miso <= tx_pick[31]; // RQ8
      end else if (sck_fall) begin
        spi_miso <= tx_shift[31]; // RQ8
        tx_shift <= {tx_shift[30:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // incoming host packets and slot store
  logic [31:0] rx_shift;
  logic [5:0] rx_bits;
  logic [20:0] slot_addr [PAP_SLOTS];
  logic [PAP_SLOTS-1:0] slot_long;
  logic [PAP_SLOTS-1:0] slot_tone;
  logic [31:0] rx_word;
  logic rx_done;

  // a frame cut short never completes, so no slot is touched
  assign rx_word = {rx_shift[30:0], mosi_sync[1]};
  assign rx_done = sck_rise && rx_bits == 6'(PAP_PKT_BITS - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_shift <= 32'h0;
      rx_bits <= 6'h0;
    end else if (clk_en) begin
      if (frame_start) begin
        rx_bits <= 6'h0;
      end else if (sck_rise) begin
        rx_shift <= rx_word;
        rx_bits <= rx_done ? 6'h0 : rx_bits + 6'h1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_long <= '0;
      slot_tone <= '0;
      for (int i = 0; i < PAP_SLOTS; i++) begin
        slot_addr[i] <= 21'h0;
      end
    end else if (clk_en && rx_done && rx_word[31:28] == PAP_ASSIGN_NIBBLE) begin // RQ26
      slot_addr[slot_of(rx_word)] <= rx_word[20:0]; // RQ1 RQ7
      slot_long[slot_of(rx_word)] <= rx_word[PAP_ASSIGN_LONG_BIT];
      slot_tone[slot_of(rx_word)] <= rx_word[PAP_ASSIGN_TONE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address matching
  logic [PAP_SLOTS-1:0] hit;
  logic [PAP_SLOTS-1:0] long_armed;
  logic [PAP_SLOTS-1:0] report;
  logic [4:0] win;
  logic addr_good;

  assign addr_good = rx_addr_valid && decode_on && rx_bit_errs <= PAP_MAX_GOOD_ERRS; // RQ21

  always_comb begin
    for (int i = 0; i < PAP_SLOTS; i++) begin
      hit[i] = slot_enable_bit[i] && slot_addr[i] == rx_addr_value; // RQ23
    end
    // long second word reports only when its even partner matched just before
    for (int j = 0; j < PAP_SLOTS / 2; j++) begin
      report[2*j] = hit[2*j] && !slot_long[2*j];
      report[2*j+1] = hit[2*j+1] && (!slot_long[2*j+1] || long_armed[2*j]); // RQ24
    end
  end

  // lowest reporting slot wins when several match
  assign win = first_set(report);

  // any other address word in between disarms the pair

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      long_armed <= '0;
    end else if (clk_en && rx_addr_valid) begin
      for (int i = 0; i < PAP_SLOTS; i++) begin
        long_armed[i] <= addr_good && hit[i] && slot_long[i] && (i % 2 == 0); // RQ3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data packet generation
  logic info_err;
  logic info_fwd;
  logic addr_fwd;
  logic [7:0] addr_index;
  logic addr_tone;

  assign info_err = rx_bit_errs > PAP_MAX_GOOD_ERRS || rx_check_fail; // RQ18
  // errored words are forwarded regardless of format; clean ones only in the set
  assign info_fwd = rx_info_valid && decode_on && !rx_info_first && send_info &&
                    (info_err || info_format_ok(rx_info_format)); // RQ13 RQ14 RQ15 RQ19
  assign addr_fwd = addr_good && (rx_temp_hit || !win[4]);
  assign addr_index = rx_temp_hit ? {PAP_TEMP_NIBBLE, rx_temp_index} : {4'h0, win[3:0]}; // RQ24
  assign addr_tone = !rx_temp_hit && slot_tone[win[3:0]];

  always_comb begin
    push = 1'b0;
    push_data = 32'h0;
    if (info_fwd) begin
      push = 1'b1;
      push_data = {PAP_ID_INFO, info_err, rx_phase, 2'h0, rx_info_format,
                   2'h0, rx_info_bits}; // RQ17 RQ20
    end else if (addr_fwd) begin
      push = 1'b1;
      push_data = {PAP_ID_ADDRESS, rx_addr_priority, rx_phase,
                   !rx_temp_hit && slot_long[win[3:0]], 4'h0,
                   addr_index, addr_tone, rx_vector_wn}; // RQ22
    end else if (rx_pkt_valid && decode_on) begin
      push = 1'b1;
      push_data = rx_pkt_data;
    end
  end

  // tells the vector stage to skip tone-only hits and error-free format 101 info words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_skip <= 1'b0;
    end else if (clk_en) begin
      vector_skip <= (addr_fwd && addr_tone) || // RQ5 RQ25
                     (rx_info_valid && !info_err && rx_info_format == PAP_FMT_SYSMSG); // RQ16
    end
  end
endmodule

// >>> sim/pap_port_assertions.sv
// property checker for the packet port, bound to pap_port
`timescale 1ns/100ps
module pap_port_assertions (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic spi_sck, // serial clock pin
  input wire logic spi_ss_n, // frame select pin
  input wire logic spi_miso, // data out
  input wire logic spi_miso_oe_n, // drive enable, active low
  input wire logic rx_info_valid, // info word strobe
  input wire logic rx_info_first, // first info word of phase
  input wire logic [1:0] rx_bit_errs, // bit errors
  input wire logic rx_check_fail, // check character failed
  input wire logic [2:0] rx_info_format, // info format
  input wire logic rx_addr_valid, // address word strobe
  input wire logic decode_on, // decoding running
  input wire logic vector_skip // skip pulse
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence frame_open;
    $fell(spi_ss_n);
  endsequence
  sequence frame_shut;
    $rose(spi_ss_n);
  endsequence
  // first word of a phase is left out here, though the port raises a skip for it too
  sequence clean_sysmsg;
    rx_info_valid && !rx_info_first && rx_info_format == 3'h5 && rx_bit_errs != 2'h3
      && !rx_check_fail && decode_on;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  a_oe_on_frame: assert property (frame_open |-> ##[1:5] !spi_miso_oe_n)
    else $error("miso not driven after frame start");
  a_oe_off_frame: assert property (frame_shut |-> ##[1:5] spi_miso_oe_n)
    else $error("miso still driven after frame end");
  a_oe_idle_line: assert property (spi_ss_n [*5] |-> spi_miso_oe_n)
    else $error("miso driven outside a frame");
  // sync delay means a bit may still move just after the rise
  a_miso_bit_hold: assert property (spi_sck [*3] |-> $stable(spi_miso))
    else $error("miso moved while serial clock high");
  a_skip_sysmsg: assert property (clean_sysmsg |=> vector_skip)
    else $error("no skip after clean system message word");
  a_skip_has_cause: assert property (vector_skip |->
      $past(rx_info_valid || (rx_addr_valid && rx_bit_errs != 2'h3)))
    else $error("skip pulse without a clean received word");
  a_skip_one_cycle: assert property (vector_skip && !rx_info_valid && !rx_addr_valid
      |=> !vector_skip)
    else $error("skip pulse longer than one cycle");
  a_skip_no_errword: assert property (rx_addr_valid && !rx_info_valid && rx_bit_errs == 2'h3
      |=> !vector_skip)
    else $error("skip pulse for an errored address");
endmodule
bind pap_port pap_port_assertions chk_u (.hclk, .hresetn, .spi_sck, .spi_ss_n, .spi_miso,
  .spi_miso_oe_n, .rx_info_valid, .rx_info_first, .rx_bit_errs, .rx_check_fail,
  .rx_info_format, .rx_addr_valid, .decode_on, .vector_skip);

// >>> sim/pap_spi_host.sv
// behavioural host microcontroller on the serial link
`timescale 1ns/100ps
module pap_spi_host (
  output logic sck, // serial clock, idle low
  output logic mosi, // host to decoder data
  output logic ss_n, // frame select, active low
  input wire logic miso // decoder to host data
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  // clock stands still between frames; released data line shows the inverse
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    #13;
    ss_n = 1'b0;
    #400;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #200;
      sck = 1'b1;
      rx[i] = miso;
      #200;
      sck = 1'b0;
    end
    #200;
    ss_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the pager address packet port
`timescale 1ns/100ps
module tb_top;
  import pap_pkg::*;
  localparam logic [31:0] ID_WORD = 32'h3c3c0001; // arbitrary identity value
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, spi_sck, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe_n, miso_line;
  logic [31:0] hrdata, rd, srx;
  logic checksum_off = 0, rx_info_valid = 0, rx_info_first = 0, rx_check_fail = 0;
  logic rx_addr_valid = 0, rx_addr_priority = 1, rx_temp_hit = 0, rx_pkt_valid = 0, sk;
  logic decode_on, vector_skip;
  logic [1:0] rx_phase = 0, rx_bit_errs = 0;
  logic [2:0] rx_info_format = 0;
  logic [13:0] rx_info_bits = 14'h2a5c;
  logic [20:0] rx_addr_value = 0;
  logic [6:0] rx_vector_wn = 7'h05;
  logic [3:0] rx_temp_index = 4'h5;
  logic [31:0] rx_pkt_data = 0;
  int err_total = 0;
  int n_compared = 0;
  always #25 hclk = ~hclk;
  // undriven miso reads as pulled high
  assign miso_line = spi_miso_oe_n ? 1'b1 : spi_miso;
  pap_port #(.PART_ID_WORD(ID_WORD)) dut_u (
    .hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .spi_sck, .spi_mosi, .spi_ss_n,
    .spi_miso, .spi_miso_oe_n, .checksum_off, .rx_info_valid, .rx_info_first, .rx_phase,
    .rx_bit_errs, .rx_check_fail, .rx_info_format, .rx_info_bits, .rx_addr_valid,
    .rx_addr_value, .rx_addr_priority, .rx_vector_wn, .rx_temp_hit, .rx_temp_index,
    .rx_pkt_valid, .rx_pkt_data, .decode_on, .vector_skip);
  pap_spi_host host_u (.sck(spi_sck), .mosi(spi_mosi), .ss_n(spi_ss_n), .miso(miso_line));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_ready;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= PAP_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic pulse(input int k);
    rx_info_valid <= (k == 0);
    rx_addr_valid <= (k == 1);
    rx_pkt_valid <= (k == 2);
    @(posedge hclk);
    rx_info_valid <= 1'b0;
    rx_addr_valid <= 1'b0;
    rx_pkt_valid <= 1'b0;
    #1;
    sk = vector_skip;
    @(posedge hclk);
  endtask
  task automatic addr_in(input logic [20:0] v, input logic [1:0] p, input logic [1:0] e,
      input logic t);
    rx_addr_value <= v;
    rx_phase <= p;
    rx_bit_errs <= e;
    rx_temp_hit <= t;
    pulse(1);
  endtask
  task automatic info_in(input logic fst, input logic [1:0] p, input logic [1:0] e,
      input logic cf, input logic [2:0] f);
    rx_info_first <= fst;
    rx_phase <= p;
    rx_bit_errs <= e;
    rx_check_fail <= cf;
    rx_info_format <= f;
    pulse(0);
  endtask
  task automatic spi(input logic [31:0] tx);
    host_u.xfer(tx, srx);
    @(posedge hclk);
  endtask
  // unused packet bits are not guaranteed, so they are masked off
  task automatic frame_chk(input string nm, input logic [31:0] m, input logic [31:0] exp);
    spi(32'h0);
    chk(nm, srx & m, exp);
  endtask
  task automatic count_chk(input string nm, input logic [31:0] exp);
    ahb(1'b0, PAP_REG_STATUS, 32'h0);
    chk(nm, rd & 32'h13f, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_regs;
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'(i * 4), 32'h0);
      chk("reset value", rd, 32'h0);
    end
    ahb(1'b1, PAP_REG_SLOT_ENABLE, 32'h0000a5a5);
    ahb(1'b1, PAP_REG_STATUS, 32'hffffffff);
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b1, PAP_REG_STATUS_PKT, 32'h5eed0042);
    ahb(1'b0, PAP_REG_SLOT_ENABLE, 32'h0);
    chk("slot enables", rd, 32'h0000a5a5);
    ahb(1'b0, PAP_REG_STATUS, 32'h0);
    chk("status read only", rd, 32'h0);
    ahb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("bus response", {hreadyout, hresp}, 32'h2);
  endtask
  task automatic s_status;
    ahb(1'b1, PAP_REG_CONTROL, 32'h2);
    frame_chk("status packet", 32'hffffffff, 32'h5eed0042);
    checksum_off <= 1'b1;
    frame_chk("part identity", 32'hffffffff, ID_WORD);
    frame_chk("part identity again", 32'hffffffff, ID_WORD);
    checksum_off <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic s_addr;
    ahb(1'b1, PAP_REG_SLOT_ENABLE, 32'h0);
    spi({4'h8, 4'h3, 3'b000, 21'h12345});
    spi({4'h8, 4'h4, 3'b001, 21'h1abcd});
    spi({4'h8, 4'h6, 3'b010, 21'h0f0f0});
    spi({4'h8, 4'h7, 3'b010, 21'h0a0a0});
    ahb(1'b1, PAP_REG_SLOT_ENABLE, 32'h000000d8);
    addr_in(21'h12345, 2'h2, 2'h2, 1'b0);
    chk("plain address skip", sk, 1'b0);
    addr_in(21'h1abcd, 2'h1, 2'h3, 1'b0);
    chk("errored address skip", sk, 1'b0);
    addr_in(21'h1abcd, 2'h1, 2'h0, 1'b0);
    chk("tone address skip", sk, 1'b1);
    addr_in(21'h0f0f0, 2'h3, 2'h1, 1'b0);
    addr_in(21'h0a0a0, 2'h3, 2'h0, 1'b0);
    rx_addr_priority <= 1'b0;
    addr_in(21'h00001, 2'h0, 2'h0, 1'b1);
    ahb(1'b1, PAP_REG_SLOT_ENABLE, 32'h000000d0);
    addr_in(21'h12345, 2'h2, 2'h0, 1'b0);
    count_chk("queued addresses", 32'h4);
    frame_chk("short address", 32'hfff0ffff, 32'h01c00305);
    frame_chk("tone address", 32'hfff0ff80, 32'h01a00480);
    frame_chk("long address", 32'hfff0ffff, 32'h01f00705);
    frame_chk("temporary address", 32'hfff0ffff, 32'h01008505);
  endtask
  task automatic s_info;
    ahb(1'b1, PAP_REG_CONTROL, 32'h3);
    info_in(1'b1, 2'h0, 2'h0, 1'b0, PAP_FMT_DATE);
    info_in(1'b0, 2'h1, 2'h0, 1'b0, PAP_FMT_DATE);
    info_in(1'b0, 2'h2, 2'h0, 1'b0, 3'h3);
    info_in(1'b0, 2'h3, 2'h3, 1'b0, 3'h3);
    info_in(1'b0, 2'h0, 2'h0, 1'b1, 3'h4);
    info_in(1'b0, 2'h0, 2'h0, 1'b0, PAP_FMT_SYSMSG);
    chk("system message skip", sk, 1'b1);
    ahb(1'b1, PAP_REG_CONTROL, 32'h2);
    info_in(1'b0, 2'h1, 2'h0, 1'b0, PAP_FMT_TIME);
    count_chk("queued info", 32'h4);
    frame_chk("date info", 32'hffe73fff, 32'h00212a5c);
    frame_chk("errored info", 32'hffe73fff, 32'h00e32a5c);
    frame_chk("check fail info", 32'hffe73fff, 32'h00842a5c);
    frame_chk("system info", 32'hffe73fff, 32'h00052a5c);
  endtask
  task automatic s_ovf;
    for (int i = 0; i < 33; i++) begin
      rx_pkt_data <= 32'h77000000 + 32'(i);
      pulse(2);
      if (i == 31) begin
        count_chk("full buffer", 32'h20);
      end
    end
    count_chk("overflow status", 32'h100);
    chk("decoding stopped", decode_on, 1'b0);
    ahb(1'b1, PAP_REG_CONTROL, 32'h6);
    count_chk("overflow cleared", 32'h0);
    rx_pkt_data <= 32'h12345678;
    pulse(2);
    frame_chk("buffered packet", 32'hffffffff, 32'h12345678);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_regs();
    s_status();
    s_addr();
    s_info();
    s_ovf();
    final_report();
  end
  // about a twentieth of this span is needed by the scenarios
  initial begin
    #4000000;
    err_total++;
    final_report();
  end
endmodule
